// *** include/pfn_consts.svh ***
// register offsets, field values and reset values of the pin function block
`ifndef PFN_CONSTS_SVH
`define PFN_CONSTS_SVH

`define PFN_OFS_A_MODE 8'h00
`define PFN_OFS_B_MODE 8'h02
`define PFN_OFS_H_MODE 8'h04
`define PFN_OFS_J_MODE 8'h06
`define PFN_OFS_SC_MODE 8'h08
`define PFN_OFS_A_DATA 8'h0A
`define PFN_OFS_B_DATA 8'h0C
`define PFN_OFS_H_DATA 8'h0E
`define PFN_OFS_J_DATA 8'h10
`define PFN_OFS_SC_DATA 8'h12

`define PFN_MODE_RST 16'h0000
`define PFN_SC_MODE_RST 16'h0A88
`define PFN_DATA_RST 8'h00

`define PFN_H_MODE_MASK 16'h3FFF
`define PFN_J_MODE_MASK 16'h00FF
`define PFN_SC_MODE_MASK 16'h0FFF
`define PFN_H_DATA_MASK 8'h7F
`define PFN_J_DATA_MASK 8'h0F
`define PFN_SC_DATA_MASK 8'h3F

`define PFN_MD_ALT 2'h0
`define PFN_MD_OUT 2'h1
`define PFN_MD_IN_PU 2'h2
`define PFN_MD_IN 2'h3

`endif

// *** include/pfn_pkg.sv ***
// types shared by the pin function block
package pfn_pkg;
   typedef enum logic [1:0] {PFN_ALT, PFN_OUT, PFN_IN_PU, PFN_IN} pfn_mode_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } pfn_bus_t;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pull;
   } pfn_pad_t;
endpackage : pfn_pkg

// *** hw/pfn_sync.sv ***
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module pfn_sync #(
   parameter int W = 8
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule : pfn_sync
`default_nettype wire

// *** hw/pfn_pin_cell.sv ***
// one multiplexed pin: mode decode, drive, pull-up and read-back selection
`timescale 1ns/10ps
`default_nettype none
module pfn_pin_cell
   import pfn_pkg::*;
#(
   parameter bit ALLOW_OUT = 1'b1,
   parameter bit HAS_PULL = 1'b1
) (
   input wire logic [1:0] i_mode,
   input wire logic i_data,
   input wire logic i_alt_out,
   input wire logic i_alt_oe,
   input wire logic i_pin,
   output logic o_out,
   output logic o_oe_n,
   output logic o_pull,
   output logic o_read
);
   pfn_mode_t mode_e;

   always_comb
   begin
      mode_e = pfn_mode_t'(i_mode);
      // prohibited output code behaves as plain input, pin left undriven
      if (!ALLOW_OUT && mode_e == PFN_OUT)
      begin
         mode_e = PFN_IN;
      end
      o_out = 1'b0;
      o_oe_n = 1'b1;
      o_pull = 1'b0;
      o_read = i_data;
      unique case (mode_e)
         PFN_ALT:
         begin
            o_out = i_alt_out;
            o_oe_n = ~i_alt_oe;
         end
         PFN_OUT:
         begin
            o_out = i_data;
            o_oe_n = 1'b0;
         end
         PFN_IN_PU:
         begin
            o_pull = HAS_PULL;
            o_read = i_pin;
         end
         PFN_IN:
         begin
            o_read = i_pin;
         end
      endcase
   end
endmodule : pfn_pin_cell
`default_nettype wire

// *** hw/pfn_pin_function.sv ***
// pin function selection and port data registers for ports a, b, h, j and serial
// Summary of operation
// - port h pins 6..0 have two-bit modes
// - port h bits 15:14 read zero
// - port j modes: function, prohibited, input
// - channel 0 enables override serial pin modes
// - channel 2 enables override serial pin modes
// - serial pin mode bits 15:12 read zero
// - serial fields 5,4,3,1 reset to pull-up input
// - serial pair 2 decodes shared pin pair
// - serial pair 0 decodes like pair 2
// - one data bit serves both pair pins
// - pair tx pin released when input, disabled
// - ports a, b have 8-bit zeroed data
// - read gives stored bit or pin level
// - writes always store; drive only in output
// - a, b pull-ups follow mode field only
// - every port has mode and data register
// - data registers cleared only by power-on reset
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pfn_consts.svh"
module pfn_pin_function
   import pfn_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire pfn_bus_t i_bus,
   output logic [15:0] o_rdata,
   input wire logic [7:0] i_pa_pin,
   output pfn_pad_t o_pa_pad,
   input wire logic [7:0] i_pa_alt_out,
   input wire logic [7:0] i_pa_alt_oe,
   output logic [7:0] o_pa_alt_in,
   input wire logic [7:0] i_pb_pin,
   output pfn_pad_t o_pb_pad,
   input wire logic [7:0] i_pb_alt_out,
   input wire logic [7:0] i_pb_alt_oe,
   output logic [7:0] o_pb_alt_in,
   input wire logic [6:0] i_ph_pin,
   output pfn_pad_t o_ph_pad,
   input wire logic [6:0] i_ph_alt_out,
   input wire logic [6:0] i_ph_alt_oe,
   output logic [6:0] o_ph_alt_in,
   input wire logic [3:0] i_pj_pin,
   input wire logic [7:0] i_sc_pin,
   output pfn_pad_t o_sc_pad,
   input wire logic [3:0] i_scp_alt_out,
   input wire logic [3:0] i_scp_alt_oe,
   output logic [3:0] o_scp_alt_in,
   input wire logic i_sci0_te,
   input wire logic i_sci0_re,
   input wire logic i_sci0_txd,
   output logic o_sci0_rxd,
   input wire logic i_sci2_te,
   input wire logic i_sci2_re,
   input wire logic i_sci2_txd,
   output logic o_sci2_rxd
);
   localparam int NSYNC = 35;

   logic [15:0] a_mode_q;
   logic [15:0] b_mode_q;
   logic [15:0] h_mode_q;
   logic [15:0] j_mode_q;
   logic [15:0] sc_mode_q;
   logic [7:0] a_data_q;
   logic [7:0] b_data_q;
   logic [7:0] h_data_q;
   logic [7:0] j_data_q;
   logic [7:0] sc_data_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic [NSYNC-1:0] pin_sync;
   logic [7:0] a_pin;
   logic [7:0] b_pin;
   logic [6:0] h_pin;
   logic [3:0] j_pin;
   logic [7:0] sc_pin;
   logic [7:0] a_read;
   logic [7:0] b_read;
   logic [6:0] h_read;
   logic [3:0] j_read;
   logic [5:0] sc_read;
   logic [6:0] h_out;
   logic [6:0] h_oe_n;
   logic [6:0] h_pull;
   logic [3:0] scs_out;
   logic [3:0] scs_oe_n;
   logic [3:0] scs_pull;
   logic [3:0] scs_read;
   logic [1:0] pr_tx_out;
   logic [1:0] pr_tx_oe_n;
   logic [1:0] pr_rx_pull;
   logic [1:0] pr_read;

   // all pin levels pass two flip-flops before use
   pfn_sync #(
      .W(NSYNC)
   ) u_sync (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_async({i_sc_pin, i_pj_pin, i_ph_pin, i_pb_pin, i_pa_pin}),
      .o_sync(pin_sync)
   );
   assign a_pin = pin_sync[7:0];
   assign b_pin = pin_sync[15:8];
   assign h_pin = pin_sync[22:16];
   assign j_pin = pin_sync[26:23];
   assign sc_pin = pin_sync[34:27];

   // mode registers; reserved bits never store
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         a_mode_q <= `PFN_MODE_RST;
         b_mode_q <= `PFN_MODE_RST;
         h_mode_q <= `PFN_MODE_RST;
         j_mode_q <= `PFN_MODE_RST;
         sc_mode_q <= `PFN_SC_MODE_RST;
      end
      else if (i_bus.wr)
      begin
         unique case (i_bus.addr)
            `PFN_OFS_A_MODE: a_mode_q <= i_bus.wdata;
            `PFN_OFS_B_MODE: b_mode_q <= i_bus.wdata;
            `PFN_OFS_H_MODE: h_mode_q <= i_bus.wdata & `PFN_H_MODE_MASK;
            `PFN_OFS_J_MODE: j_mode_q <= i_bus.wdata & `PFN_J_MODE_MASK;
            `PFN_OFS_SC_MODE: sc_mode_q <= i_bus.wdata & `PFN_SC_MODE_MASK;
            default:
            begin
            end
         endcase
      end
   end

   // data registers; only the power-on reset clears them
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         a_data_q <= `PFN_DATA_RST;
         b_data_q <= `PFN_DATA_RST;
         h_data_q <= `PFN_DATA_RST;
         j_data_q <= `PFN_DATA_RST;
         sc_data_q <= `PFN_DATA_RST;
      end
      else if (i_bus.wr)
      begin
         unique case (i_bus.addr)
            `PFN_OFS_A_DATA: a_data_q <= i_bus.wdata[7:0];
            `PFN_OFS_B_DATA: b_data_q <= i_bus.wdata[7:0];
            `PFN_OFS_H_DATA: h_data_q <= i_bus.wdata[7:0] & `PFN_H_DATA_MASK;
            `PFN_OFS_J_DATA: j_data_q <= i_bus.wdata[7:0] & `PFN_J_DATA_MASK;
            `PFN_OFS_SC_DATA: sc_data_q <= i_bus.wdata[7:0] & `PFN_SC_DATA_MASK;
            default:
            begin
            end
         endcase
      end
   end

   // ports a, b and h share one pin cell type
   for (genvar i = 0; i < 8; i++)
   begin : g_ab
      pfn_pin_cell u_a (
         .i_mode(a_mode_q[2*i+1:2*i]),
         .i_data(a_data_q[i]),
         .i_alt_out(i_pa_alt_out[i]),
         .i_alt_oe(i_pa_alt_oe[i]),
         .i_pin(a_pin[i]),
         .o_out(o_pa_pad.out[i]),
         .o_oe_n(o_pa_pad.oe_n[i]),
         .o_pull(o_pa_pad.pull[i]),
         .o_read(a_read[i])
      );
      pfn_pin_cell u_b (
         .i_mode(b_mode_q[2*i+1:2*i]),
         .i_data(b_data_q[i]),
         .i_alt_out(i_pb_alt_out[i]),
         .i_alt_oe(i_pb_alt_oe[i]),
         .i_pin(b_pin[i]),
         .o_out(o_pb_pad.out[i]),
         .o_oe_n(o_pb_pad.oe_n[i]),
         .o_pull(o_pb_pad.pull[i]),
         .o_read(b_read[i])
      );
   end
   for (genvar i = 0; i < 7; i++)
   begin : g_h
      pfn_pin_cell u_h (
         .i_mode(h_mode_q[2*i+1:2*i]),
         .i_data(h_data_q[i]),
         .i_alt_out(i_ph_alt_out[i]),
         .i_alt_oe(i_ph_alt_oe[i]),
         .i_pin(h_pin[i]),
         .o_out(h_out[i]),
         .o_oe_n(h_oe_n[i]),
         .o_pull(h_pull[i]),
         .o_read(h_read[i])
      );
   end
   assign o_ph_pad = '{out: {1'b0, h_out}, oe_n: {1'b1, h_oe_n}, pull: {1'b0, h_pull}};

   // port j pins are never driven digitally and have no pull-up
   for (genvar i = 0; i < 4; i++)
   begin : g_j
      // prohibited code 01 reads like input, as any non-function code does
      assign j_read[i] = (j_mode_q[2*i+1:2*i] != `PFN_MD_ALT) ? j_pin[i] : j_data_q[i];
   end

   // single serial-port pins: fields 1, 3, 4, 5; field 5 has no output code
   for (genvar k = 0; k < 4; k++)
   begin : g_scs
      localparam int F = (k == 0) ? 1 : k + 2;
      localparam int P = (k == 0) ? 2 : k + 4;
      pfn_pin_cell #(
         .ALLOW_OUT(k != 3),
         .HAS_PULL(1'b1)
      ) u_s (
         .i_mode(sc_mode_q[2*F+1:2*F]),
         .i_data(sc_data_q[F]),
         .i_alt_out(i_scp_alt_out[k]),
         .i_alt_oe(i_scp_alt_oe[k]),
         .i_pin(sc_pin[P]),
         .o_out(scs_out[k]),
         .o_oe_n(scs_oe_n[k]),
         .o_pull(scs_pull[k]),
         .o_read(scs_read[k])
      );
   end

   // serial pin pairs 0 and 2: one data bit, tx pin out, rx pin in
   for (genvar p = 0; p < 2; p++)
   begin : g_pair
      logic [1:0] md;
      logic te;
      logic re;
      logic txd;
      assign md = sc_mode_q[4*p+1:4*p];
      assign te = (p == 0) ? i_sci0_te : i_sci2_te;
      assign re = (p == 0) ? i_sci0_re : i_sci2_re;
      assign txd = (p == 0) ? i_sci0_txd : i_sci2_txd;
      always_comb
      begin
         pr_tx_out[p] = txd;
         pr_tx_oe_n[p] = 1'b0;
         if (!te && md == `PFN_MD_OUT)
         begin
            pr_tx_out[p] = sc_data_q[2*p];
         end
         else if (!te && md[1])
         begin
            pr_tx_out[p] = 1'b0;
            pr_tx_oe_n[p] = 1'b1;
         end
      end
      assign pr_rx_pull[p] = !re && md == `PFN_MD_IN_PU;
      // input only while the receiver is off, so never both directions at once
      assign pr_read[p] = (!re && md[1]) ? sc_pin[3*p+1] : sc_data_q[2*p];
   end

   assign o_sc_pad = '{
      out: {scs_out[3:1], 1'b0, pr_tx_out[1], scs_out[0], 1'b0, pr_tx_out[0]},
      oe_n: {scs_oe_n[3:1], 1'b1, pr_tx_oe_n[1], scs_oe_n[0], 1'b1, pr_tx_oe_n[0]},
      pull: {scs_pull[3:1], pr_rx_pull[1], 1'b0, scs_pull[0], pr_rx_pull[0], 1'b0}
   };
   assign sc_read = {scs_read[3:1], pr_read[1], scs_read[0], pr_read[0]};
   assign o_sci0_rxd = sc_pin[1];
   assign o_sci2_rxd = sc_pin[4];
   assign o_pa_alt_in = a_pin;
   assign o_pb_alt_in = b_pin;
   assign o_ph_alt_in = h_pin;
   assign o_scp_alt_in = {sc_pin[7:5], sc_pin[2]};

   // read data: one cycle after the strobe, zero otherwise and when unmapped
   always_comb
   begin
      rdata_d = 16'h0000;
      if (i_bus.rd)
      begin
         unique case (i_bus.addr)
            `PFN_OFS_A_MODE: rdata_d = a_mode_q;
            `PFN_OFS_B_MODE: rdata_d = b_mode_q;
            `PFN_OFS_H_MODE: rdata_d = h_mode_q;
            `PFN_OFS_J_MODE: rdata_d = j_mode_q;
            `PFN_OFS_SC_MODE: rdata_d = sc_mode_q;
            `PFN_OFS_A_DATA: rdata_d = {8'h00, a_read};
            `PFN_OFS_B_DATA: rdata_d = {8'h00, b_read};
            `PFN_OFS_H_DATA: rdata_d = {9'h000, h_read};
            `PFN_OFS_J_DATA: rdata_d = {12'h000, j_read};
            `PFN_OFS_SC_DATA: rdata_d = {10'h000, sc_read};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rdata_q <= 16'h0000;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end
   assign o_rdata = rdata_q;

   a_out_drive_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      a_mode_q[3:2] == `PFN_MD_OUT |-> !o_pa_pad.oe_n[1] && o_pa_pad.out[1] == a_data_q[1])
      else $error("port a pin 1 not driven with data in output mode");
   b_input_float_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      b_mode_q[15] |-> o_pb_pad.oe_n[7])
      else $error("port b pin 7 driven in input mode");
   pull_follow_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pa_pad.pull[3] == (a_mode_q[7:6] == `PFN_MD_IN_PU))
      else $error("port a pin 3 pull-up not following its mode");
   read_pin_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_bus.rd && i_bus.addr == `PFN_OFS_A_DATA && a_mode_q[5]
      |=> o_rdata[2] == $past(a_pin[2]) && o_rdata[15:8] == 8'h00)
      else $error("port a read does not return pin level in input mode");
   data_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_bus.wr && i_bus.addr == `PFN_OFS_B_DATA |=> b_data_q == $past(i_bus.wdata[7:0]))
      else $error("port b data write not stored");
   data_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(i_bus.wr && i_bus.addr == `PFN_OFS_A_DATA) |=> $stable(a_data_q))
      else $error("port a data changed without a write");
   h_reserved_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_bus.rd && i_bus.addr == `PFN_OFS_H_MODE |=> o_rdata[15:14] == 2'h0)
      else $error("port h reserved bits read nonzero");
   sc_reserved_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_bus.rd && i_bus.addr == `PFN_OFS_SC_MODE |=> o_rdata[15:12] == 4'h0)
      else $error("serial pin mode reserved bits read nonzero");
   tx0_override_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_sci0_te |-> !o_sc_pad.oe_n[0] && o_sc_pad.out[0] == i_sci0_txd)
      else $error("channel 0 transmit pin not serial while enabled");
   tx2_override_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_sci2_te |-> !o_sc_pad.oe_n[3] && o_sc_pad.out[3] == i_sci2_txd)
      else $error("channel 2 transmit pin not serial while enabled");
   tx_release_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sc_mode_q[1] && !i_sci0_te |-> o_sc_pad.oe_n[0])
      else $error("pair 0 transmit pin driven in input mode");
   pair2_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sc_mode_q[5:4] == `PFN_MD_OUT && !i_sci2_te
      |-> o_sc_pad.out[3] == sc_data_q[2] && o_sc_pad.oe_n[4])
      else $error("pair 2 general output wrong");
   sc_reset_a: assert property (@(posedge i_clk)
      $rose(i_resetn) |-> sc_mode_q == `PFN_SC_MODE_RST)
      else $error("serial pin mode reset value wrong");
endmodule : pfn_pin_function
`default_nettype wire

// *** tb/pfn_pins_model.sv ***
// pin level model: pad drive, external drive, pull-up or floating
`timescale 1ns/10ps
`default_nettype none
module pfn_pins_model
   import pfn_pkg::*;
(
   input wire logic i_clk,
   input wire pfn_pad_t i_pad,
   input wire logic [7:0] i_ext,
   input wire logic [7:0] i_ext_en,
   output logic [7:0] o_level
);
   logic [7:0] float_q = 8'h00;
   // a floating pin wanders so a stale level never reads as valid
   always_ff @(posedge i_clk)
   begin
      float_q <= ~float_q;
   end
   always_comb
   begin
      for (int n = 0; n < 8; n++)
      begin
         if (!i_pad.oe_n[n])
            o_level[n] = i_pad.out[n];
         else if (i_ext_en[n])
            o_level[n] = i_ext[n];
         else if (i_pad.pull[n])
            o_level[n] = 1'b1;
         else
            o_level[n] = float_q[n];
      end
   end
endmodule : pfn_pins_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the pin function block
`timescale 1ns/10ps
`default_nettype none
`include "pfn_consts.svh"
module tb;
   import pfn_pkg::*;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic [15:0] exp;
   } pfn_row_t;
   logic clk;
   logic resetn;
   pfn_bus_t bus;
   logic [15:0] rdata;
   pfn_pad_t pa_pad, pb_pad, ph_pad, sc_pad;
   logic [7:0] pa_lvl, pb_lvl, ph_lvl, sc_lvl, alt_out, alt_oe;
   logic [7:0] ext_lvl, pa_alt_in, pb_alt_in;
   logic [6:0] ph_alt_in;
   logic [3:0] pj_pin, scp_alt_in;
   logic te0, re0, serial0_transmit_pin, te2, re2, serial2_transmit_pin, serial0_receive_pin, serial2_receive_pin;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   pfn_row_t rows [7] = '{
      '{`PFN_OFS_A_DATA, 16'h00A5, 16'h00A5},
      '{`PFN_OFS_B_DATA, 16'hFF5A, 16'h005A},
      '{`PFN_OFS_H_MODE, 16'hFFFF, 16'h3FFF},
      '{`PFN_OFS_J_MODE, 16'hFFFF, 16'h00FF},
      '{`PFN_OFS_SC_MODE, 16'hFFFF, 16'h0FFF},
      '{`PFN_OFS_B_MODE, 16'hC00C, 16'hC00C},
      '{8'h20, 16'hFFFF, 16'h0000}
   };

   pfn_pin_function u_pfn_pin_function (.i_clk(clk), .i_resetn(resetn), .i_bus(bus),
      .o_rdata(rdata), .i_pa_pin(pa_lvl), .o_pa_pad(pa_pad), .i_pa_alt_out(alt_out),
      .i_pa_alt_oe(alt_oe), .o_pa_alt_in(pa_alt_in), .i_pb_pin(pb_lvl), .o_pb_pad(pb_pad),
      .i_pb_alt_out(alt_out), .i_pb_alt_oe(alt_oe), .o_pb_alt_in(pb_alt_in),
      .i_ph_pin(ph_lvl[6:0]), .o_ph_pad(ph_pad), .i_ph_alt_out(alt_out[6:0]),
      .i_ph_alt_oe(alt_oe[6:0]), .o_ph_alt_in(ph_alt_in),
      .i_pj_pin(pj_pin), .i_sc_pin(sc_lvl), .o_sc_pad(sc_pad), .i_scp_alt_out(alt_out[3:0]),
      .i_scp_alt_oe(alt_oe[3:0]), .o_scp_alt_in(scp_alt_in), .i_sci0_te(te0), .i_sci0_re(re0),
      .i_sci0_txd(serial0_transmit_pin), .o_sci0_rxd(serial0_receive_pin), .i_sci2_te(te2), .i_sci2_re(re2),
      .i_sci2_txd(serial2_transmit_pin), .o_sci2_rxd(serial2_receive_pin));
   // external drivers share one level word; pins 3 and 7 of port a are held low
   pfn_pins_model u_pa_pins (.i_clk(clk), .i_pad(pa_pad), .i_ext(ext_lvl), .i_ext_en(8'h88),
      .o_level(pa_lvl));
   pfn_pins_model u_pb_pins (.i_clk(clk), .i_pad(pb_pad), .i_ext(ext_lvl), .i_ext_en(8'hFF),
      .o_level(pb_lvl));
   pfn_pins_model u_ph_pins (.i_clk(clk), .i_pad(ph_pad), .i_ext(ext_lvl), .i_ext_en(8'h7F),
      .o_level(ph_lvl));
   // receive pins of both channels are driven from outside
   pfn_pins_model u_sc_pins (.i_clk(clk), .i_pad(sc_pad), .i_ext(ext_lvl), .i_ext_en(8'h12),
      .o_level(sc_lvl));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rchk

   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic results;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         results();
      end
   end

   initial
   begin
      resetn = 1'b0;
      bus = '0;
      alt_out = 8'h00;
      alt_oe = 8'hFF;
      ext_lvl = 8'h02;
      pj_pin = 4'hA;
      {te0, re0, serial0_transmit_pin, te2, re2, serial2_transmit_pin} = 6'b000001;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk(rdata, 16'h0000);
      rchk(`PFN_OFS_SC_MODE, 16'h0A88);
      rchk(`PFN_OFS_A_DATA, 16'h0000);
      rchk(`PFN_OFS_H_MODE, 16'h0000);
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata);
         rchk(rows[i].addr, rows[i].exp);
      end
      settle();
      chk({8'h00, ph_pad.oe_n}, 16'h00FF);
      chk({8'h00, ph_pad.pull}, 16'h0000);
      chk({9'h000, ph_alt_in}, 16'h0002);
      chk({8'h00, pb_pad.oe_n}, 16'h0082);
      chk({8'h00, pb_alt_in}, 16'h0002);
      // no analog output exists here, so port j input is a safe choice
      rchk(`PFN_OFS_J_DATA, 16'h000A);
      // prohibited code reads the pin like an input
      wr(`PFN_OFS_J_MODE, 16'h0055);
      rchk(`PFN_OFS_J_DATA, 16'h000A);
      // port a pins cycle through peripheral, output, pulled input, plain input
      wr(`PFN_OFS_A_MODE, 16'hE4E4);
      wr(`PFN_OFS_A_DATA, 16'h00FF);
      settle();
      chk({8'h00, pa_pad.oe_n}, 16'h00CC);
      chk({8'h00, pa_pad.pull}, 16'h0044);
      chk({8'h00, pa_pad.out & 8'h33}, 16'h0022);
      chk({8'h00, pa_alt_in}, 16'h0066);
      rchk(`PFN_OFS_A_DATA, 16'h0077);
      wr(`PFN_OFS_A_DATA, 16'h0000);
      settle();
      chk({8'h00, pa_pad.out & 8'h33}, 16'h0000);
      rchk(`PFN_OFS_A_DATA, 16'h0044);
      // pair 0 as general output, pair 2 as plain input
      wr(`PFN_OFS_SC_MODE, 16'h0AB9);
      wr(`PFN_OFS_SC_DATA, 16'h0005);
      settle();
      rchk(`PFN_OFS_SC_DATA, 16'h003B);
      chk({8'h00, sc_pad.oe_n & 8'h09}, 16'h0008);
      chk({15'h0000, sc_pad.out[0]}, 16'h0001);
      @(posedge clk);
      te0 <= 1'b1;
      te2 <= 1'b1;
      re2 <= 1'b1;
      settle();
      chk({8'h00, sc_pad.oe_n & 8'h09}, 16'h0000);
      chk({8'h00, sc_pad.out & 8'h09}, 16'h0008);
      rchk(`PFN_OFS_SC_DATA, 16'h003F);
      chk({14'h0000, serial2_receive_pin, serial0_receive_pin}, 16'h0001);
      // pair 0 as pulled input, field 1 as output, pair 2 as general output
      @(posedge clk);
      te0 <= 1'b0;
      te2 <= 1'b0;
      re2 <= 1'b0;
      wr(`PFN_OFS_SC_MODE, 16'h0A96);
      wr(`PFN_OFS_SC_DATA, 16'h0004);
      settle();
      chk({8'h00, sc_pad.oe_n & 8'h0F}, 16'h0003);
      chk({8'h00, sc_pad.out & 8'h0F}, 16'h0008);
      chk({8'h00, sc_pad.pull}, 16'h00E2);
      chk({12'h000, scp_alt_in}, 16'h000E);
      rchk(`PFN_OFS_SC_DATA, 16'h003D);
      // a second power-on reset in mid-run must clear stored data
      wr(`PFN_OFS_A_DATA, 16'h00A5);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rchk(`PFN_OFS_A_DATA, 16'h0000);
      rchk(`PFN_OFS_SC_MODE, 16'h0A88);
      results();
   end
endmodule : tb
`default_nettype wire
